// >>> common/tis_params.svh
`ifndef TIS_PARAMS_SVH
`define TIS_PARAMS_SVH

// ****************************************************************
// register indices; the byte address is four times the index
// ****************************************************************
`define TIS_IDX_DEV_STATE   8'h02
`define TIS_IDX_FLAGS_PRI   8'h03
`define TIS_IDX_FLAGS_SEC   8'h04
`define TIS_IDX_MASK_PRI    8'h05
`define TIS_IDX_MASK_SEC    8'h06
`define TIS_IDX_QUEUE_CTRL  8'h08
`define TIS_IDX_FULL_LEVEL  8'h7c
`define TIS_IDX_EMPTY_LEVEL 8'h7d

// ****************************************************************
// bus geometry
// ****************************************************************
`define TIS_ADDR_W          10
`define TIS_IDX_LSB         2
`define TIS_RESP_OKAY       2'b00
`define TIS_RESP_SLVERR     2'b10

// ****************************************************************
// reset values and field layout
// ****************************************************************
`define TIS_MASK_PRI_RST    8'h00
`define TIS_MASK_SEC_RST    8'h03
`define TIS_FULL_LEVEL_RST  6'h37
`define TIS_EMPTY_LEVEL_RST 6'h04
`define TIS_PRI_VALID       8'hec
`define TIS_SEC_VALID       8'h0f
`define TIS_PRI_RD_CLEAR    8'h6c
`define TIS_LEVEL_W         6
`define TIS_CNT_W           7
`define TIS_BIT_FERR        7
`define TIS_BIT_AFULL       6
`define TIS_BIT_AEMPTY      5
`define TIS_BIT_EXT         3
`define TIS_BIT_PKSENT      2
`define TIS_BIT_WUT         3
`define TIS_BIT_LBD         2
`define TIS_BIT_CHIPRDY     1
`define TIS_BIT_POR         0
`define TIS_BIT_QCLR        0
`define TIS_CPS_IDLE        2'b00
`define TIS_CPS_TX          2'b10

`endif

// >>> common/tis_pkg.sv
`include "tis_params.svh"
`default_nettype none

package tis_pkg;
  typedef logic [7:0]                tis_byte_type;
  typedef logic [`TIS_ADDR_W-1:0]    tis_addr_type;
  typedef logic [`TIS_LEVEL_W-1:0]   tis_level_type;
  typedef logic [`TIS_CNT_W-1:0]     tis_cnt_type;
endpackage

`default_nettype wire

// >>> hw/tis_irq_status.sv
// Contract
// - an enabled primary flag rising pulls irq_out_low low.
// - a primary read releases the line and clears enabled bits except fifo error.
// - a read leaves a primary flag with a clear enable unchanged.
// - fifo error sets on overflow or underflow, clears on fifo reset.
// - almost-full sets above its level, clears sending at or below.
// - almost-empty is set at or below its level, cleared above it.
// - packet-sent sets on a clean send, clears on start or fifo exit.
// - the external flag sets on the configured gpio event.
// - device state shows overflow in bit 7 and underflow in bit 6.
// - the power state field reads 00 when idle, 10 when sending.
// - an enable of one lets its event drive the line, zero keeps status.
// - enabled secondary flags drive the line; a read clears only those.
// - low battery stays latched while disabled, interrupts once enabled.
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "tis_params.svh"
`default_nettype none

module tis_irq_status
  import tis_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // axi4-lite slave
  input  wire logic [9:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [9:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // transmit path and chip status events, same clock
  input  wire logic [6:0]  tx_fifo_count_i,
  input  wire logic        tx_fifo_ovfl_i,
  input  wire logic        tx_fifo_unfl_i,
  input  wire logic        tx_active_i,
  input  wire logic        tx_start_i,
  input  wire logic        pkt_sent_i,
  input  wire logic        fifo_mode_i,
  input  wire logic        wut_expire_i,
  input  wire logic        low_batt_i,
  input  wire logic        chip_ready_i,
  input  wire logic        back_to_idle_i,
  input  wire logic        por_event_i,
  // gpio pin configured as interrupt source, asynchronous
  input  wire logic        gpio_event_pin_i,
  output logic             tx_fifo_clear_o,
  output logic             irq_out_low_o
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic idx_hit(input tis_addr_type a,
                                   input tis_byte_type idx);
    idx_hit = (a[1:0] == 2'b00) &&
              (a[`TIS_ADDR_W-1:`TIS_IDX_LSB] == idx);
  endfunction

  function automatic logic idx_known(input tis_addr_type a);
    idx_known = idx_hit(a, `TIS_IDX_DEV_STATE)  |
                idx_hit(a, `TIS_IDX_FLAGS_PRI)  |
                idx_hit(a, `TIS_IDX_FLAGS_SEC)  |
                idx_hit(a, `TIS_IDX_MASK_PRI)   |
                idx_hit(a, `TIS_IDX_MASK_SEC)   |
                idx_hit(a, `TIS_IDX_QUEUE_CTRL) |
                idx_hit(a, `TIS_IDX_FULL_LEVEL) |
                idx_hit(a, `TIS_IDX_EMPTY_LEVEL);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic          awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic          aw_have_r, w_have_r;
  tis_addr_type  awaddr_r;
  tis_byte_type  wdata_r;
  logic          wstrb0_r;
  logic [1:0]    bresp_r, rresp_r;
  tis_byte_type  rdata_r, rdata_nxt;
  tis_byte_type  flags_pri_r, flags_pri_nxt;
  tis_byte_type  flags_sec_r, flags_sec_nxt;
  tis_byte_type  mask_pri_r, mask_sec_r;
  tis_level_type full_level_r, empty_level_r;
  logic          qclr_r, fifo_clear_r, irq_n_r;
  logic          ovfl_r, unfl_r;
  logic          gpio_s1_r, gpio_s2_r, gpio_s3_r;
  logic          chip_ready_d_r;

  // ****************************************************************
  // bus handshakes
  // ****************************************************************
  wire logic aw_fire  = s_axi_awvalid_i & awready_r;
  wire logic w_fire   = s_axi_wvalid_i & wready_r;
  wire logic b_fire   = bvalid_r & s_axi_bready_i;
  wire logic ar_fire  = s_axi_arvalid_i & arready_r;
  wire logic r_fire   = rvalid_r & s_axi_rready_i;
  wire logic do_write = aw_have_r & w_have_r & ~bvalid_r;
  // only the low byte lane carries register data
  wire logic wr_ok    = do_write & idx_known(awaddr_r) & wstrb0_r;

  wire logic wr_mask_pri = wr_ok & idx_hit(awaddr_r, `TIS_IDX_MASK_PRI);
  wire logic wr_mask_sec = wr_ok & idx_hit(awaddr_r, `TIS_IDX_MASK_SEC);
  wire logic wr_flg_pri  = wr_ok & idx_hit(awaddr_r, `TIS_IDX_FLAGS_PRI);
  wire logic wr_flg_sec  = wr_ok & idx_hit(awaddr_r, `TIS_IDX_FLAGS_SEC);
  wire logic wr_qctrl    = wr_ok & idx_hit(awaddr_r, `TIS_IDX_QUEUE_CTRL);
  wire logic wr_full     = wr_ok & idx_hit(awaddr_r, `TIS_IDX_FULL_LEVEL);
  wire logic wr_empty    = wr_ok & idx_hit(awaddr_r, `TIS_IDX_EMPTY_LEVEL);
  wire logic rd_pri      = ar_fire & idx_hit(s_axi_araddr_i,
                                             `TIS_IDX_FLAGS_PRI);
  wire logic rd_sec      = ar_fire & idx_hit(s_axi_araddr_i,
                                             `TIS_IDX_FLAGS_SEC);

  // ready drops once a beat is held and returns when the response is accepted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `TIS_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awready_r <= 1'b0;
        aw_have_r <= 1'b1;
      end
      if (w_fire) begin
        wready_r <= 1'b0;
        w_have_r <= 1'b1;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= idx_known(awaddr_r) ? `TIS_RESP_OKAY
                                         : `TIS_RESP_SLVERR;
      end
      if (b_fire) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // write payload capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb0_r <= 1'b0;
    end else begin
      if (aw_fire) awaddr_r <= s_axi_awaddr_i;
      if (w_fire) begin
        wdata_r  <= s_axi_wdata_i[7:0];
        wstrb0_r <= s_axi_wstrb_i[0];
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire tis_byte_type dev_state = {ovfl_r, unfl_r, 4'h0,
                                  tx_active_i ? `TIS_CPS_TX
                                              : `TIS_CPS_IDLE};
  always_comb begin
    rdata_nxt = 8'h00;
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_DEV_STATE))   rdata_nxt = dev_state;
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_FLAGS_PRI))   rdata_nxt = flags_pri_r;
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_FLAGS_SEC))   rdata_nxt = flags_sec_r;
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_MASK_PRI))    rdata_nxt = mask_pri_r;
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_MASK_SEC))    rdata_nxt = mask_sec_r;
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_QUEUE_CTRL))  rdata_nxt = {7'h00, qclr_r};
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_FULL_LEVEL))  rdata_nxt = {2'b00, full_level_r};
    if (idx_hit(s_axi_araddr_i, `TIS_IDX_EMPTY_LEVEL)) rdata_nxt = {2'b00, empty_level_r};
  end

  // the read-clear acts at the address edge, so rdata shows the pre-clear value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 8'h00;
      rresp_r   <= `TIS_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rdata_nxt;
        rresp_r   <= idx_known(s_axi_araddr_i) ? `TIS_RESP_OKAY
                                               : `TIS_RESP_SLVERR;
      end else if (r_fire) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // fifo reset only on the 1-then-0 write pair of the clear bit
  wire logic qclr_fall = wr_qctrl & qclr_r & ~wdata_r[`TIS_BIT_QCLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_pri_r    <= `TIS_MASK_PRI_RST;
      mask_sec_r    <= `TIS_MASK_SEC_RST;
      full_level_r  <= `TIS_FULL_LEVEL_RST;
      empty_level_r <= `TIS_EMPTY_LEVEL_RST;
      qclr_r        <= 1'b0;
      fifo_clear_r  <= 1'b0;
    end else begin
      if (wr_mask_pri) mask_pri_r <= wdata_r & `TIS_PRI_VALID;
      if (wr_mask_sec) mask_sec_r <= wdata_r & `TIS_SEC_VALID;
      if (wr_full)     full_level_r  <= wdata_r[`TIS_LEVEL_W-1:0];
      if (wr_empty)    empty_level_r <= wdata_r[`TIS_LEVEL_W-1:0];
      if (wr_qctrl)    qclr_r <= wdata_r[`TIS_BIT_QCLR];
      fifo_clear_r <= qclr_fall;
    end
  end

  // ****************************************************************
  // gpio event pin synchroniser and edge detect
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_s1_r      <= 1'b0;
      gpio_s2_r      <= 1'b0;
      gpio_s3_r      <= 1'b0;
      chip_ready_d_r <= 1'b0;
    end else begin
      gpio_s1_r      <= gpio_event_pin_i;
      gpio_s2_r      <= gpio_s1_r;
      gpio_s3_r      <= gpio_s2_r;
      chip_ready_d_r <= chip_ready_i;
    end
  end

  // ****************************************************************
  // event flags; a set in the clearing cycle wins
  // ****************************************************************
  wire tis_cnt_type full_ext  = {1'b0, full_level_r};
  wire tis_cnt_type empty_ext = {1'b0, empty_level_r};
  wire logic af_over  = tx_fifo_count_i > full_ext;
  wire logic af_auto  = tx_active_i & ~af_over;
  wire logic ae_below = tx_fifo_count_i <= empty_ext;
  wire logic ps_auto  = tx_start_i | ~fifo_mode_i;
  wire logic ext_set  = gpio_s2_r & ~gpio_s3_r;
  wire logic ferr_set = tx_fifo_ovfl_i | tx_fifo_unfl_i;

  wire tis_byte_type set_pri  = {ferr_set, af_over, ae_below, 1'b0,
                                 ext_set, pkt_sent_i, 2'b00};
  wire tis_byte_type auto_pri = {fifo_clear_r, af_auto, ~ae_below, 1'b0,
                                 1'b0, ps_auto, 2'b00};
  // error bit is left out of the read-clear: only fifo reset drops it
  wire tis_byte_type clr_pri  = ({8{rd_pri}} & mask_pri_r &
                                 `TIS_PRI_RD_CLEAR) |
                                ({8{wr_flg_pri}} & wdata_r &
                                 `TIS_PRI_RD_CLEAR);
  wire tis_byte_type set_sec  = {4'h0, wut_expire_i, low_batt_i,
                                 chip_ready_i & ~chip_ready_d_r,
                                 por_event_i};
  wire tis_byte_type auto_sec = {6'h00, back_to_idle_i, 1'b0};
  wire tis_byte_type clr_sec  = ({8{rd_sec}} & mask_sec_r) |
                                ({8{wr_flg_sec}} & wdata_r);

  assign flags_pri_nxt = ((flags_pri_r & ~clr_pri & ~auto_pri) | set_pri) &
                         `TIS_PRI_VALID;
  assign flags_sec_nxt = ((flags_sec_r & ~clr_sec & ~auto_sec) | set_sec) &
                         `TIS_SEC_VALID;

  // line follows pending enabled bits of both registers
  wire logic pend_nxt = |(flags_pri_nxt & mask_pri_r) |
                        |(flags_sec_nxt & mask_sec_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_pri_r <= 8'h00;
      flags_sec_r <= 8'h00;
      ovfl_r      <= 1'b0;
      unfl_r      <= 1'b0;
      irq_n_r     <= 1'b1;
    end else begin
      flags_pri_r <= flags_pri_nxt;
      flags_sec_r <= flags_sec_nxt;
      ovfl_r      <= tx_fifo_ovfl_i | (ovfl_r & ~fifo_clear_r);
      unfl_r      <= tx_fifo_unfl_i | (unfl_r & ~fifo_clear_r);
      irq_n_r     <= ~pend_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = {24'h000000, rdata_r};
  assign tx_fifo_clear_o = fifo_clear_r;
  assign irq_out_low_o   = irq_n_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  // one clock domain: clock and reset are given once for every check
  default clocking chk_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_irq_on_event: assert property (
    |(set_pri & mask_pri_r) |=> !irq_out_low_o)
    else $error("enabled event did not pull the line low");
  chk_read_release: assert property (
    (rd_pri & ~|set_pri & ~|(flags_sec_r & mask_sec_r) & ~|set_sec &
     ~flags_pri_r[`TIS_BIT_FERR]) |=> irq_out_low_o)
    else $error("primary read did not release the line");
  chk_unen_keep: assert property (
    (rd_pri & ~wr_flg_pri & ~ps_auto & ~mask_pri_r[`TIS_BIT_PKSENT] &
     flags_pri_r[`TIS_BIT_PKSENT]) |=> flags_pri_r[`TIS_BIT_PKSENT])
    else $error("read cleared a disabled flag");
  chk_ferr_hold: assert property (
    (flags_pri_r[`TIS_BIT_FERR] & ~fifo_clear_r) |=>
    flags_pri_r[`TIS_BIT_FERR])
    else $error("fifo error dropped without fifo reset");
  chk_afull_set: assert property (
    af_over |=> flags_pri_r[`TIS_BIT_AFULL])
    else $error("almost full not set above level");
  chk_aempty_level: assert property (
    (tx_fifo_count_i > empty_ext) |=> !flags_pri_r[`TIS_BIT_AEMPTY])
    else $error("almost empty still set above level");
  chk_pksent_clear: assert property (
    (tx_start_i & ~pkt_sent_i) |=> !flags_pri_r[`TIS_BIT_PKSENT])
    else $error("packet sent survived a new start");
  chk_ext_edge: assert property (
    $rose(gpio_s2_r) |=> flags_pri_r[`TIS_BIT_EXT])
    else $error("gpio event not latched");
  chk_lbd_latch: assert property (
    (flags_sec_r[`TIS_BIT_LBD] & ~clr_sec[`TIS_BIT_LBD]) |=>
    flags_sec_r[`TIS_BIT_LBD])
    else $error("low battery flag lost");
  chk_sec_release: assert property (
    (rd_sec & mask_sec_r[`TIS_BIT_POR] & ~por_event_i) |=>
    !flags_sec_r[`TIS_BIT_POR])
    else $error("secondary read left enabled bit set");
  chk_pend_low: assert property (
    |(flags_pri_r & mask_pri_r & ~clr_pri & ~auto_pri) |=> !irq_out_low_o)
    else $error("line high while a flag is pending");
  chk_qclr_seq: assert property (
    tx_fifo_clear_o |-> $past(qclr_r) && $past(qclr_fall) && !qclr_r)
    else $error("fifo clear without the write pair");

endmodule

`default_nettype wire

// >>> testbench/tis_host_model.sv
`include "tis_params.svh"
`default_nettype none

// ****************************************************************
// host side: axi4-lite master driven by software-style tasks
// ****************************************************************
module tis_host_model
  import tis_pkg::*;
(
  input  wire logic        clk_i,
  output logic [9:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [9:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
    {bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end

  // released payloads are scrambled so a late sample cannot pass
  task automatic wr(input tis_byte_type idx, input tis_byte_type val,
                    output logic [1:0] resp);
    @(posedge clk_i);
    awaddr_o  <= {idx, 2'b00};
    wdata_o   <= {24'h0, val};
    wstrb_o   <= 4'h1;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~awaddr_o;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~wdata_o;
      end
    end while (!bvalid_i);
    resp = bresp_i;
    bready_o <= 1'b0;
  endtask

  // one read; data is taken at the edge that sees rvalid
  task automatic rd(input tis_byte_type idx, output logic [31:0] data,
                    output logic [1:0] resp);
    @(posedge clk_i);
    araddr_o  <= {idx, 2'b00};
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~araddr_o;
      end
    end while (!rvalid_i);
    data = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> testbench/tb_tis_irq_status.sv
`include "tis_params.svh"
`default_nettype none

// ****************************************************************
// bench: register accesses and event stimulus with expected values
// ****************************************************************
module tb_tis_irq_status
  import tis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  ev = 8'h0;
  tis_cnt_type cnt = 7'h0a;
  logic        tx_act = 1'b0, fifo_mode = 1'b1, chip_rdy = 1'b0;
  logic        gpio = 1'b0;
  wire         tx_clr, irq_out_low;
  wire  [9:0]  awaddr, araddr;
  wire  [31:0] wdata, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp;
  wire         awvalid, awready, wvalid, wready, bvalid, bready;
  wire         arvalid, arready, rvalid, rready;
  int          n_mismatch = 0, comparisons = 0, cycles = 0, n_clr = 0;
  tis_byte_type ri [7] = '{`TIS_IDX_MASK_PRI, `TIS_IDX_MASK_SEC,
    `TIS_IDX_FULL_LEVEL, `TIS_IDX_EMPTY_LEVEL, `TIS_IDX_DEV_STATE,
    `TIS_IDX_FLAGS_PRI, `TIS_IDX_FLAGS_SEC};
  tis_byte_type rv [7] = '{8'h00, 8'h03, 8'h37, 8'h04, 8'h00, 8'h00, 8'h00};

  always #10 clk_i = ~clk_i;

  tis_irq_status u_tis_irq_status (.clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .tx_fifo_count_i(cnt),
    .tx_fifo_ovfl_i(ev[0]), .tx_fifo_unfl_i(ev[1]),
    .tx_active_i(tx_act), .tx_start_i(ev[2]), .pkt_sent_i(ev[3]),
    .fifo_mode_i(fifo_mode), .wut_expire_i(ev[4]),
    .low_batt_i(ev[5]), .chip_ready_i(chip_rdy),
    .back_to_idle_i(ev[7]), .por_event_i(ev[6]),
    .gpio_event_pin_i(gpio), .tx_fifo_clear_o(tx_clr),
    .irq_out_low_o(irq_out_low));

  tis_host_model u_tis_host_model (.clk_i(clk_i), .awaddr_o(awaddr),
    .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready));

  // a hang ends the run as a failure rather than stalling forever
  always @(posedge clk_i) begin
    cycles++;
    if (tx_clr === 1'b1) n_clr++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // irq is registered: look just after the edge has landed
  task automatic cmp_irq(input logic exp);
    #1;
    cmp_val({31'h0, irq_out_low}, {31'h0, exp});
  endtask

  task automatic rchk(input tis_byte_type idx, input tis_byte_type exp);
    logic [31:0] d;
    logic [1:0]  r;
    u_tis_host_model.rd(idx, d, r);
    cmp_val(d, {24'h0, exp});
    cmp_val({30'h0, r}, {30'h0, `TIS_RESP_OKAY});
  endtask

  task automatic wreg(input tis_byte_type idx, input tis_byte_type val);
    logic [1:0] r;
    u_tis_host_model.wr(idx, val, r);
    cmp_val({30'h0, r}, {30'h0, `TIS_RESP_OKAY});
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    ev <= 8'h1 << k;
    @(posedge clk_i);
    ev <= 8'h0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ri[i]) rchk(ri[i], rv[i]);
    wreg(`TIS_IDX_MASK_PRI, 8'hff);
    rchk(`TIS_IDX_MASK_PRI, 8'hec);
    wreg(`TIS_IDX_MASK_PRI, 8'h00);
    u_tis_host_model.wr(8'h40, 8'h5a, r);
    cmp_val({30'h0, r}, {30'h0, `TIS_RESP_SLVERR});
    u_tis_host_model.rd(8'h40, d, r);
    cmp_val(d, 32'h0);
    cmp_val({30'h0, r}, {30'h0, `TIS_RESP_SLVERR});
    // fifo levels with no primary enables: flags only, line idle
    @(posedge clk_i);
    cnt <= 7'h04;
    rchk(`TIS_IDX_FLAGS_PRI, 8'h20);
    cmp_irq(1'b1);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h20);
    @(posedge clk_i);
    cnt <= 7'h38;
    rchk(`TIS_IDX_FLAGS_PRI, 8'h40);
    @(posedge clk_i);
    tx_act <= 1'b1;
    cnt <= 7'h37;
    rchk(`TIS_IDX_FLAGS_PRI, 8'h00);
    rchk(`TIS_IDX_DEV_STATE, 8'h02);
    @(posedge clk_i);
    tx_act <= 1'b0;
    cnt <= 7'h0a;
    // packet-sent cleared by a new start and by leaving fifo mode
    pulse(3);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h04);
    pulse(2);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h00);
    pulse(3);
    @(posedge clk_i);
    fifo_mode <= 1'b0;
    @(posedge clk_i);
    fifo_mode <= 1'b1;
    rchk(`TIS_IDX_FLAGS_PRI, 8'h00);
    // enabled event pulls the line, read releases and clears
    wreg(`TIS_IDX_MASK_PRI, 8'h04);
    pulse(3);
    cmp_irq(1'b0);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h04);
    cmp_irq(1'b1);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h00);
    // fifo error survives reads until the two-write fifo reset
    pulse(0);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h80);
    rchk(`TIS_IDX_DEV_STATE, 8'h80);
    pulse(1);
    rchk(`TIS_IDX_DEV_STATE, 8'hc0);
    wreg(`TIS_IDX_QUEUE_CTRL, 8'h01);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h80);
    wreg(`TIS_IDX_QUEUE_CTRL, 8'h00);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h00);
    rchk(`TIS_IDX_DEV_STATE, 8'h00);
    cmp_val(n_clr, 32'h1);
    // external pin event
    wreg(`TIS_IDX_MASK_PRI, 8'h08);
    @(posedge clk_i);
    gpio <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp_irq(1'b0);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h08);
    cmp_irq(1'b1);
    @(posedge clk_i);
    gpio <= 1'b0;
    // secondary flags: read clears enabled bits only
    pulse(4);
    cmp_irq(1'b1);
    pulse(6);
    cmp_irq(1'b0);
    rchk(`TIS_IDX_FLAGS_SEC, 8'h09);
    cmp_irq(1'b1);
    rchk(`TIS_IDX_FLAGS_SEC, 8'h08);
    // low battery latched while masked, interrupts once enabled
    pulse(5);
    cmp_irq(1'b1);
    wreg(`TIS_IDX_MASK_SEC, 8'h04);
    cmp_irq(1'b0);
    wreg(`TIS_IDX_MASK_PRI, 8'h04);
    pulse(3);
    rchk(`TIS_IDX_FLAGS_SEC, 8'h0c);
    cmp_irq(1'b0);
    rchk(`TIS_IDX_FLAGS_PRI, 8'h04);
    cmp_irq(1'b1);
    rchk(`TIS_IDX_FLAGS_SEC, 8'h08);
    @(posedge clk_i);
    chip_rdy <= 1'b1;
    rchk(`TIS_IDX_FLAGS_SEC, 8'h0a);
    pulse(7);
    rchk(`TIS_IDX_FLAGS_SEC, 8'h08);
    summarize();
  end
endmodule

`default_nettype wire
